// [src/slsa_pkg.sv]
// Purpose: Shared types and constants for the shift-left and subtract datapath slice
// Assumes: 16-bit data path, AXI4-Lite register access with 32-bit data
// Notes:   Flag layout in the status word is fixed by slsa_flags_type; the localparams below match it
package slsa_pkg;

    localparam int unsigned DATA_W    = 16;
    localparam int unsigned LIT_W     = 10;
    localparam int unsigned DEST_W    = 4;
    localparam int unsigned ADDR_W    = 4;
    localparam int unsigned SHIFT_LIM = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFFS_RESULT = 4'h4;

    // Status word bit positions
    localparam int unsigned POS_CARRY    = 0;
    localparam int unsigned POS_ZERO     = 1;
    localparam int unsigned POS_OVERFLOW = 2;
    localparam int unsigned POS_NEGATIVE = 3;
    localparam int unsigned POS_DIGIT    = 4;

    // Index of the default working register
    localparam logic [DEST_W-1:0] DEFAULT_WORKING_REGISTER = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SLSA_SHIFT_LEFT_OP             = 5'h01,
        SLSA_SUBTRACT_OP               = 5'h02,
        SLSA_SUBTRACT_WITH_BORROW_OP   = 5'h04,
        SLSA_REVERSE_SUBTRACT_OP       = 5'h08,
        SLSA_REVERSE_SUBTRACT_BORROW_OP = 5'h10
    } slsa_op_type;

    typedef enum logic [3:0] {
        SLSA_FORM_REG         = 4'h1,
        SLSA_FORM_LIT5        = 4'h2,
        SLSA_FORM_LIT10       = 4'h4,
        SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER = 4'h8
    } slsa_form_type;

    typedef struct packed {
        logic digit_carry_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
        logic carry;
    } slsa_flags_type;

    typedef struct packed {
        logic                valid;
        slsa_op_type         op;
        slsa_form_type       form;
        logic [DATA_W-1:0]   base_operand_register;
        logic [DATA_W-1:0]   source_operand_register;
        logic [LIT_W-1:0]    literal;
        logic [DEST_W-1:0]   destination_register;
    } slsa_req_type;

    typedef struct packed {
        logic                valid;
        logic [DATA_W-1:0]   data;
        logic [DEST_W-1:0]   dest;
        slsa_flags_type      flags;
    } slsa_res_type;

    typedef struct packed {
        slsa_flags_type      flags;
        logic [DATA_W-1:0]   last_result;
        slsa_res_type        res;
        logic                aw_held;
        logic [ADDR_W-1:0]   aw_addr;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } slsa_state_type;

    localparam slsa_state_type STATE_RESET = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// [src/slsa_alu.sv]
// Purpose: One-cycle shift-left and subtract slice with AXI4-Lite status access
// Assumes: Decoder supplies fetched operand values and literal in one request
// Notes:   Tags below mark the logic that carries out each rule
// Functional notes
// RULE1 - Register-count shift left, N and Z only
// RULE2 - Literal5 shift left, N and Z only
// RULE3 - Register subtract with borrow, all five flags
// RULE4 - Literal10 subtract with borrow into same register
// RULE5 - Memory minus default register minus borrow
// RULE6 - Literal5 subtract with borrow, all flags
// RULE7 - Plain subtract no borrow; reverse swaps operands
`timescale 1ns/1ps
`default_nettype none

module slsa_alu (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Decoder request and result
    input  wire slsa_pkg::slsa_req_type req,
    output var  slsa_pkg::slsa_res_type res,
    // AXI4-Lite write
    input  wire logic                  awvalid,
    input  wire logic [3:0]            awaddr,
    output logic                       awready,
    input  wire logic                  wvalid,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    output logic                       wready,
    output logic                       bvalid,
    output logic [1:0]                 bresp,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic                  arvalid,
    input  wire logic [3:0]            araddr,
    output logic                       arready,
    output logic                       rvalid,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    input  wire logic                  rready
);
    import slsa_pkg::*;

    slsa_state_type    st;
    slsa_state_type    next_st;
    logic [DATA_W-1:0] opnd_b;
    logic [DATA_W-1:0] sub_x;
    logic [DATA_W-1:0] sub_y;
    logic              carry_in;
    logic [DATA_W:0]   diff;
    logic [4:0]        low_nib;
    logic [4:0]        count;
    logic [DATA_W-1:0] shifted;
    logic              reverse;
    slsa_flags_type    status_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection and arithmetic

    always_comb begin
        case (req.form)
            SLSA_FORM_LIT5:  opnd_b = {11'h000, req.literal[4:0]}; // see RULE6
            SLSA_FORM_LIT10: opnd_b = {6'h00, req.literal}; // see RULE4
            default:         opnd_b = req.source_operand_register;
        endcase
        reverse = (req.op == SLSA_REVERSE_SUBTRACT_OP)
               || (req.op == SLSA_REVERSE_SUBTRACT_BORROW_OP);
        // Reverse forms take the other operand first // see RULE7
        sub_x = reverse ? opnd_b : req.base_operand_register;
        sub_y = reverse ? req.base_operand_register : opnd_b;
        // Borrow is the inverted carry; plain forms inject a fixed one // see RULE3
        carry_in = ((req.op == SLSA_SUBTRACT_WITH_BORROW_OP)
                 || (req.op == SLSA_REVERSE_SUBTRACT_BORROW_OP)) ? st.flags.carry : 1'b1;
        diff    = {1'b0, sub_x} + {1'b0, ~sub_y} + {16'h0000, carry_in};
        low_nib = {1'b0, sub_x[3:0]} + {1'b0, ~sub_y[3:0]} + {4'h0, carry_in};
        // Count comes from a register or the 5-bit literal // see RULE1 RULE2
        count   = (req.form == SLSA_FORM_LIT5) ? req.literal[4:0]
                                               : req.source_operand_register[4:0];
        // Counts of 16 and above push every bit out
        shifted = (count >= 5'(SHIFT_LIM)) ? 16'h0000
                                           : req.base_operand_register << count[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st           = st;
        next_st.res.valid = 1'b0;
        status_wr         = slsa_flags_type'(st.w_data[4:0]);

        // Write channel: address and data taken independently
        if (awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_SLVERR;
            if (st.aw_addr[3:2] == OFFS_STATUS[3:2]) begin
                next_st.bresp = RESP_OKAY;
                if (st.w_strb[0]) begin
                    next_st.flags = status_wr;
                end
            end else if (st.aw_addr[3:2] == OFFS_RESULT[3:2]) begin
                next_st.bresp = RESP_OKAY;
            end
        end

        // Read channel
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            if (araddr[3:2] == OFFS_STATUS[3:2]) begin
                next_st.rdata[4:0] = st.flags;
            end else if (araddr[3:2] == OFFS_RESULT[3:2]) begin
                next_st.rdata[15:0] = st.last_result;
            end else begin
                next_st.rresp = RESP_SLVERR;
            end
        end

        // Datapath: a subtract overrides a status write in the same cycle; a shift overrides only N and Z
        if (req.valid) begin
            next_st.res.valid = 1'b1;
            next_st.res.dest  = req.destination_register;
            if (req.op == SLSA_SHIFT_LEFT_OP) begin
                // Carry and overflow keep their value // see RULE1 RULE2
                next_st.res.data       = shifted;
                next_st.flags.negative = shifted[15];
                next_st.flags.zero     = (shifted == 16'h0000);
            end else begin
                next_st.res.data               = diff[15:0];
                next_st.flags.carry            = diff[16];
                next_st.flags.digit_carry_flag = low_nib[4];
                next_st.flags.negative         = diff[15];
                next_st.flags.zero             = (diff[15:0] == 16'h0000);
                next_st.flags.overflow_flag    = (sub_x[15] != sub_y[15])
                                              && (diff[15] != sub_x[15]); // see RULE3 RULE6
                // A memory-form subtract always lands in the default register // see RULE5
                if (req.form == SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER) begin
                    next_st.res.dest = DEFAULT_WORKING_REGISTER;
                end
            end
            next_st.res.flags   = next_st.flags;
            next_st.last_result = next_st.res.data;
        end

        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign res     = st.res;
    assign awready = st.awready;
    assign wready  = st.wready;
    assign bvalid  = st.bvalid;
    assign bresp   = st.bresp;
    assign arready = st.arready;
    assign rvalid  = st.rvalid;
    assign rdata   = st.rdata;
    assign rresp   = st.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_shift_reg_data: assert property ( // see RULE1
        req.valid && req.op == SLSA_SHIFT_LEFT_OP && req.form == SLSA_FORM_REG
        && !req.source_operand_register[4]
        |=> res.data == 16'($past(req.base_operand_register)
                            << $past(req.source_operand_register[3:0])))
        else $error("register shift result wrong");
    chk_shift_keeps_cov: assert property ( // see RULE2
        req.valid && req.op == SLSA_SHIFT_LEFT_OP
        |=> res.flags.carry == $past(st.flags.carry)
            && res.flags.overflow_flag == $past(st.flags.overflow_flag))
        else $error("shift touched carry or overflow");
    chk_lit_shift_out: assert property ( // see RULE2
        req.valid && req.op == SLSA_SHIFT_LEFT_OP && req.form == SLSA_FORM_LIT5
        && req.literal[4]
        |=> res.data == 16'h0000 && res.flags.zero)
        else $error("large literal shift not cleared");
    chk_borrow_reg_data: assert property ( // see RULE3
        req.valid && req.op == SLSA_SUBTRACT_WITH_BORROW_OP && req.form == SLSA_FORM_REG
        |=> res.data == 16'($past(req.base_operand_register)
                - $past(req.source_operand_register) - 16'(!$past(st.flags.carry))))
        else $error("borrow subtract result wrong");
    chk_lit10_same_dest: assert property ( // see RULE4
        req.valid && req.form == SLSA_FORM_LIT10 && req.op != SLSA_SHIFT_LEFT_OP
        |=> res.dest == $past(req.destination_register) && res.valid)
        else $error("literal10 destination wrong");
    chk_mem_to_default: assert property ( // see RULE5
        req.valid && req.op == SLSA_SUBTRACT_WITH_BORROW_OP
        && req.form == SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER
        |=> res.dest == DEFAULT_WORKING_REGISTER)
        else $error("memory form missed default register");
    chk_lit5_borrow: assert property ( // see RULE6
        req.valid && req.op == SLSA_SUBTRACT_WITH_BORROW_OP && req.form == SLSA_FORM_LIT5
        |=> res.data == 16'($past(req.base_operand_register)
                - 16'($past(req.literal[4:0])) - 16'(!$past(st.flags.carry))))
        else $error("literal5 borrow subtract wrong");
    chk_reverse_order: assert property ( // see RULE7
        req.valid && req.op == SLSA_REVERSE_SUBTRACT_OP && req.form == SLSA_FORM_REG
        |=> res.data == 16'($past(req.source_operand_register)
                            - $past(req.base_operand_register))
            && res.flags.carry == ($past(req.source_operand_register)
                                   >= $past(req.base_operand_register)))
        else $error("reverse subtract wrong");
    chk_result_pulse: assert property (
        res.valid |-> $past(req.valid) && res.flags.zero == (res.data == 16'h0000))
        else $error("result strobe or zero flag wrong");

    cov_borrow_chain: cover property (
        req.valid && req.op == SLSA_SUBTRACT_WITH_BORROW_OP && !st.flags.carry);
    cov_shift_reg: cover property (
        req.valid && req.op == SLSA_SHIFT_LEFT_OP && req.form == SLSA_FORM_REG);
    cov_status_write: cover property (st.bvalid && st.bresp == RESP_OKAY);

endmodule

`default_nettype wire

// [verif/slsa_decoder_model.sv]
// Purpose: Instruction decoder and working register file seen from the slice
// Assumes: One request per call, launched right after a rising edge
// Notes:   Idle cycles invert the base and source operands, not the literal, so stale values are never reused
`timescale 1ns/1ps
`default_nettype none

module slsa_decoder_model (
    // Clock
    input  wire logic                   clk_sys,
    // Request toward the slice
    output var  slsa_pkg::slsa_req_type req
);
    import slsa_pkg::*;

    initial req = '0;

    task automatic issue(input slsa_op_type op, input slsa_form_type form,
                         input logic [15:0] b, s, input logic [9:0] lit, input logic [3:0] d);
        req <= '{valid: 1'b1, op: op, form: form, base_operand_register: b,
                 source_operand_register: s, literal: lit, destination_register: d};
        @(posedge clk_sys);
    endtask

    task automatic idle();
        req.valid                   <= 1'b0;
        req.base_operand_register   <= ~req.base_operand_register;
        req.source_operand_register <= ~req.source_operand_register;
        @(posedge clk_sys);
    endtask

endmodule

`default_nettype wire

// [verif/slsa_alu_bench.sv]
// Purpose: Self-checking bench for the shift-left and subtract slice
// Assumes: Results arrive one cycle after each request, in order
// Notes:   Flag model kept as {digit, negative, overflow, zero, carry}
`timescale 1ns/1ps
`default_nettype none

module slsa_alu_bench;
    import slsa_pkg::*;

    logic         clk_sys = 1'b0;
    logic         reset   = 1'b1;
    slsa_req_type req;
    slsa_res_type res;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]   awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0]  wdata = 32'h0;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    int           error_cnt = 0, check_count = 0;
    logic [15:0]  rng = 16'h000e;
    logic [4:0]   mflags = 5'h00;
    logic [15:0]  mlast = 16'h0000;
    logic [24:0]  exp_q[$];
    slsa_op_type   ops[5] = '{SLSA_SHIFT_LEFT_OP, SLSA_SUBTRACT_OP, SLSA_SUBTRACT_WITH_BORROW_OP,
                              SLSA_REVERSE_SUBTRACT_OP, SLSA_REVERSE_SUBTRACT_BORROW_OP};
    slsa_form_type forms[4] = '{SLSA_FORM_REG, SLSA_FORM_LIT5, SLSA_FORM_LIT10,
                                SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER};

    always #5 clk_sys = ~clk_sys;

    slsa_decoder_model DEC (.clk_sys(clk_sys), .req(req));

    slsa_alu DUT (.clk_sys(clk_sys), .reset(reset), .req(req), .res(res),
        .awvalid(awvalid), .awaddr(awaddr), .awready(awready), .wvalid(wvalid),
        .wdata(wdata), .wstrb(wstrb), .wready(wready), .bvalid(bvalid), .bresp(bresp),
        .bready(bready), .arvalid(arvalid), .araddr(araddr), .arready(arready),
        .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));

    function automatic logic [15:0] xs();
        rng = rng ^ (rng << 7);
        rng = rng ^ (rng >> 9);
        rng = rng ^ (rng << 8);
        return rng;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic run(input slsa_op_type op, input slsa_form_type form,
                       input logic [15:0] b, s, input logic [9:0] lit, input logic [3:0] d);
        logic [16:0] x, y;
        logic [4:0]  dig;
        logic [4:0]  sc;
        logic [15:0] r;
        logic        cin;
        x = {1'b0, b};
        y = (form inside {SLSA_FORM_REG, SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER}) ? {1'b0, s} :
            (form == SLSA_FORM_LIT5) ? 17'(lit[4:0]) : 17'(lit);
        if (form == SLSA_FORM_MEM_TO_DEFAULT_WORKING_REGISTER && op != SLSA_SHIFT_LEFT_OP)
            d = DEFAULT_WORKING_REGISTER;
        if (op == SLSA_SHIFT_LEFT_OP) begin
            // Only the 5-bit literal form takes its count from the instruction
            sc = (form == SLSA_FORM_LIT5) ? lit[4:0] : s[4:0];
            r  = (sc >= 5'd16) ? 16'h0000 : b << sc;
            mflags[3] = r[15];
            mflags[1] = (r == 16'h0000);
        end else begin
            if (op inside {SLSA_REVERSE_SUBTRACT_OP, SLSA_REVERSE_SUBTRACT_BORROW_OP})
                {x, y} = {y, x};
            cin = (op inside {SLSA_SUBTRACT_WITH_BORROW_OP, SLSA_REVERSE_SUBTRACT_BORROW_OP})
                ? mflags[0] : 1'b1;
            {mflags[0], r} = x + {1'b0, ~y[15:0]} + 17'(cin);
            dig = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
            mflags = {dig[4], r[15], (x[15] != y[15]) && (r[15] != x[15]),
                      r == 16'h0000, mflags[0]};
        end
        exp_q.push_back({r, d, mflags});
        mlast = r;
        DEC.issue(op, form, b, s, lit, d);
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] er);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= dv;
        wstrb   <= 4'hf;
        bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
        // One edge passes so a following call never re-raises ready in this step
        @(posedge clk_sys);
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        check("rdata", rdata, ev);
        check("rresp", 32'(rresp), 32'(er));
        @(posedge clk_sys);
    endtask

    // Results are compared mid-cycle, away from the edge that updates them
    always @(negedge clk_sys) begin
        if (res.valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected result", 32'h1, 32'h0);
            else check("result", 32'({res.data, res.dest, res.flags}),
                       32'(exp_q.pop_front()));
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Counts 0 to 30 in steps of 5; those past the width must clear the result
        foreach (forms[f]) if (f < 2) for (int c = 0; c < 32; c += 5)
            run(SLSA_SHIFT_LEFT_OP, forms[f], xs(), {xs() & 16'hffe0} | 16'(c),
                10'(c), 4'(c));
        DEC.idle();
        $display("shift test done");
        for (int c = 0; c < 2; c++) begin
            repeat (2) DEC.idle();
            axi_write(OFFS_STATUS, 32'(c), RESP_OKAY);
            mflags = 5'(c);
            foreach (ops[o]) foreach (forms[f])
                run(ops[o], forms[f], xs(), xs(),
                    10'(xs()), 4'(xs()));
            run(SLSA_SUBTRACT_OP, SLSA_FORM_REG, 16'h8000, 16'h0001,
                10'h000, 4'h3);
            run(SLSA_SUBTRACT_WITH_BORROW_OP, SLSA_FORM_REG, 16'h1234, 16'h1234,
                10'h000, 4'h5);
        end
        repeat (2) DEC.idle();
        $display("subtract test done");
        axi_read(OFFS_STATUS, 32'(mflags), RESP_OKAY);
        axi_read(OFFS_RESULT, 32'(mlast), RESP_OKAY);
        axi_read(4'h8, 32'h0, RESP_SLVERR);
        axi_write(4'hc, 32'h1f, RESP_SLVERR);
        axi_write(OFFS_RESULT, 32'hffff, RESP_OKAY);
        axi_read(OFFS_RESULT, 32'(mlast), RESP_OKAY);
        axi_read(OFFS_STATUS, 32'(mflags), RESP_OKAY);
        $display("register test done");
        // A result that never came would otherwise go unnoticed
        check("pending results", 32'(exp_q.size()), 32'h0);
        print_verdict();
    end

endmodule

`default_nettype wire
